// ==== rtl/ilc_ahb_if.sv ====
// AHB-Lite slave front end: address phase capture and access strobes.
module ilc_ahb_if
	import ilc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output logic rd_en,
	output logic wr_en,
	output logic [11:0] rd_addr,
	output logic [11:0] wr_addr
);
	typedef struct packed {
		logic wr_pend;
		logic [11:0] waddr;
	} ilc_ahb_state_t;

	ilc_ahb_state_t s_q;
	ilc_ahb_state_t s_d;
	logic take;

	always_comb begin
		// Only whole-word transfers are acted on; others complete quietly.
		take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
		s_d = s_q;
		if (hready) begin
			s_d.wr_pend = take && hwrite;
			s_d.waddr = {haddr[11:2], 2'h0};
		end
		rd_en = take && !hwrite;
		rd_addr = {haddr[11:2], 2'h0};
		wr_en = s_q.wr_pend && hready;
		wr_addr = s_q.waddr;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : ilc_ahb_if

// ==== rtl/ilc_lane.sv ====
// One interpolator lane: operand select, shift, mask, sign fill and add.
module ilc_lane
	import ilc_pkg::*;
(
	input wire logic [31:0] acc_own,
	input wire logic [31:0] acc_other,
	input wire logic [31:0] offset,
	input wire logic [31:0] ctrl,
	output logic [31:0] masked,
	output logic [31:0] result,
	output logic [1:0] excess
);
	logic [31:0] sel;
	logic [31:0] shifted;
	logic [31:0] keep;
	logic [31:0] low;
	logic [4:0] msb;
	logic [4:0] sh;

	always_comb begin
		msb = ctrl[F_MSB +: 5];
		sh = ctrl[F_SHIFT +: 5];
		// The swap sits before the bypass, so it also steers the raw add.
		sel = ctrl[F_XIN] ? acc_other : acc_own;
		shifted = sel >> sh;
		keep = 32'hffff_ffff >> (5'h1f - msb);
		low = 32'hffff_ffff << ctrl[F_LSB +: 5];
		masked = shifted & keep & low;
		if (ctrl[F_SIGN] && masked[msb]) begin
			masked = masked | ~keep;
		end
		excess[0] = |((acc_own >> sh) & ~keep);
		excess[1] = |((acc_other >> sh) & ~keep);
		if (ctrl[F_RAW]) begin
			result = offset + sel;
		end else begin
			result = offset + masked;
		end
	end

endmodule : ilc_lane

// ==== rtl/ilc_lane_ctrl.sv ====
// Interpolator lane block: registers, lane datapaths and bus slave.
//
// Notes on behaviour
// - Reading the second lane view returns its result, changing nothing.
// - Reading the full view returns the combined result, changing nothing.
// - Control bit 25 reads one when either excess flag is one.
// - Control bit 24 shows accumulator b bits above the mask top.
// - Control bit 23 shows accumulator a bits above the mask top.
// - Bits 20:19 are ORed into result bits 29:28 on bus reads.
// - That OR touches only bus data, never the internal result.
// - Bit 18 bypasses shift and mask; full result still uses them.
// - Bit 17 makes a pop load accumulator a from the second lane.
// - Bit 16 feeds accumulator b into the first lane's shift and mask.
// - The operand swap acts ahead of the bypass.
// - Bits 9:5 give the lowest passed bit; lower bits read zero.
// - Bits 4:0 give a zero-filling right shift before masking.
// - With sign set, the masked value is sign filled from the top.
// - A pop returns a result and loads both accumulators at once.
//
// Chosen here: the AHB-Lite register port.
module ilc_lane_ctrl
	import ilc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ
);
	typedef struct packed {
		logic [31:0] acc_a;
		logic [31:0] acc_b;
		logic [31:0] off_a;
		logic [31:0] off_b;
		logic [31:0] off_c;
		logic [31:0] ctrl0;
		logic [31:0] ctrl1;
		logic [1:0] status;
		logic [1:0] mask;
		logic any_seen;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic irq;
	} ilc_state_t;

	ilc_state_t s_q;
	ilc_state_t s_d;

	logic rd_en;
	logic wr_en;
	logic [11:0] rd_addr;
	logic [11:0] wr_addr;
	logic [31:0] m0;
	logic [31:0] m1;
	logic [31:0] res0;
	logic [31:0] res1;
	logic [31:0] full;
	logic [1:0] ex0;
	logic ex_a;
	logic ex_b;
	logic ex_any;
	logic [31:0] res0_bus;
	logic [31:0] res1_bus;
	logic [31:0] ctrl0_rd;
	logic [31:0] rdat;
	logic pop;
	logic [1:0] st_set;
	logic [1:0] st_clr;
	logic [31:0] win0;

	ilc_ahb_if u_bus (
		.clk(CLK),
		.rst_n(RST_N),
		.hsel(HSEL),
		.haddr(HADDR),
		.htrans(HTRANS),
		.hwrite(HWRITE),
		.hsize(HSIZE),
		.hready(HREADY),
		.rd_en(rd_en),
		.wr_en(wr_en),
		.rd_addr(rd_addr),
		.wr_addr(wr_addr)
	);

	ilc_lane u_first_lane (
		.acc_own(s_q.acc_a),
		.acc_other(s_q.acc_b),
		.offset(s_q.off_a),
		.ctrl(s_q.ctrl0),
		.masked(m0),
		.result(res0),
		.excess(ex0)
	);

	ilc_lane u_second_lane (
		.acc_own(s_q.acc_b),
		.acc_other(s_q.acc_a),
		.offset(s_q.off_b),
		.ctrl(s_q.ctrl1),
		.masked(m1),
		.result(res1),
		.excess()
	);

	always_comb begin
		s_d = s_q;
		pop = 1'b0;
		rdat = WORD_RESET;
		st_set = 2'h0;
		st_clr = 2'h0;
		ex_a = ex0[0];
		ex_b = ex0[1];
		ex_any = ex_a | ex_b;
		// Pass window of the first lane, kept apart for the checks below.
		win0 = (32'hffff_ffff >> (5'h1f - s_q.ctrl0[F_MSB +: 5])) &
			(32'hffff_ffff << s_q.ctrl0[F_LSB +: 5]);
		// The full sum ignores the bypass and always uses masked values.
		full = s_q.off_c + m0 + m1;
		// Forced top bits only decorate bus data; a pop feeds back res0 and res1.
		res0_bus = res0 | {2'h0, s_q.ctrl0[F_FORCE +: 2], 28'h0};
		res1_bus = res1 | {2'h0, s_q.ctrl1[F_FORCE +: 2], 28'h0};
		ctrl0_rd = s_q.ctrl0 & CTRL_WR_MASK;
		ctrl0_rd[F_EXA] = ex_a;
		ctrl0_rd[F_EXB] = ex_b;
		ctrl0_rd[F_ANY] = ex_any;
		if (rd_en) begin
			if (rd_addr == ADDR_ACCUM_A) begin
				rdat = s_q.acc_a;
			end else if (rd_addr == ADDR_ACCUM_B) begin
				rdat = s_q.acc_b;
			end else if (rd_addr == ADDR_OFFSET_A) begin
				rdat = s_q.off_a;
			end else if (rd_addr == ADDR_OFFSET_B) begin
				rdat = s_q.off_b;
			end else if (rd_addr == ADDR_OFFSET_C) begin
				rdat = s_q.off_c;
			end else if (rd_addr == ADDR_POP_A) begin
				rdat = res0_bus;
				pop = 1'b1;
			end else if (rd_addr == ADDR_POP_B) begin
				rdat = res1_bus;
				pop = 1'b1;
			end else if (rd_addr == ADDR_POP_FULL) begin
				rdat = full;
				pop = 1'b1;
			end else if (rd_addr == ADDR_VIEW_A) begin
				rdat = res0_bus;
			end else if (rd_addr == ADDR_SECOND_LANE_VIEW) begin
				rdat = res1_bus;
			end else if (rd_addr == ADDR_FULL_VIEW) begin
				rdat = full;
			end else if (rd_addr == ADDR_FIRST_LANE_CTRL) begin
				rdat = ctrl0_rd;
			end else if (rd_addr == ADDR_SECOND_LANE_CTRL) begin
				rdat = s_q.ctrl1 & CTRL_WR_MASK;
			end else if (rd_addr == ADDR_IRQ_STATUS) begin
				rdat = {30'h0, s_q.status};
			end else if (rd_addr == ADDR_IRQ_MASK) begin
				rdat = {30'h0, s_q.mask};
			end else begin
				rdat = WORD_RESET;
			end
		end
		s_d.rdata = rdat;
		if (pop) begin
			// Both accumulators load in the same cycle as the returned word.
			s_d.acc_a = s_q.ctrl0[F_XRES] ? res1 : res0;
			s_d.acc_b = s_q.ctrl1[F_XRES] ? res0 : res1;
			st_set[ST_POP] = 1'b1;
		end
		if (wr_en) begin
			if (wr_addr == ADDR_ACCUM_A) begin
				s_d.acc_a = HWDATA;
			end else if (wr_addr == ADDR_ACCUM_B) begin
				s_d.acc_b = HWDATA;
			end else if (wr_addr == ADDR_OFFSET_A) begin
				s_d.off_a = HWDATA;
			end else if (wr_addr == ADDR_OFFSET_B) begin
				s_d.off_b = HWDATA;
			end else if (wr_addr == ADDR_OFFSET_C) begin
				s_d.off_c = HWDATA;
			end else if (wr_addr == ADDR_FIRST_LANE_CTRL) begin
				s_d.ctrl0 = HWDATA & CTRL_WR_MASK;
			end else if (wr_addr == ADDR_SECOND_LANE_CTRL) begin
				s_d.ctrl1 = HWDATA & CTRL_WR_MASK;
			end else if (wr_addr == ADDR_IRQ_STATUS) begin
				st_clr = HWDATA[1:0];
			end else if (wr_addr == ADDR_IRQ_MASK) begin
				s_d.mask = HWDATA[1:0];
			end else begin
				s_d.mask = s_q.mask;
			end
		end
		s_d.any_seen = ex_any;
		st_set[ST_EXCESS] = ex_any && !s_q.any_seen;
		// A new event in the clearing cycle survives the clear.
		s_d.status = (s_q.status & ~st_clr) | st_set;
		s_d.irq = |(s_d.status & s_d.mask);
		s_d.ready = 1'b1;
		s_d.resp = 1'b0;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.ctrl0 <= CTRL_RESET;
			s_q.ctrl1 <= CTRL_RESET;
			s_q.status <= IRQ_RESET;
			s_q.mask <= IRQ_RESET;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign HRDATA = s_q.rdata;
	assign HREADYOUT = s_q.ready;
	assign HRESP = s_q.resp;
	assign IRQ = s_q.irq;

	default clocking dcb @(posedge CLK);
	endclocking

	default disable iff (!RST_N);

	sequence s_read_at(logic [11:0] a);
		rd_en && (rd_addr == a);
	endsequence

	sequence s_quiet_read_at(logic [11:0] a);
		s_read_at(a) ##0 !wr_en;
	endsequence

	chk_view_keeps_state: assert property (
		s_quiet_read_at(ADDR_SECOND_LANE_VIEW) |=>
		$stable(s_q.acc_a) && $stable(s_q.acc_b)
	) else $error("lane view read changed an accumulator");

	chk_view_second_lane_data: assert property (
		s_read_at(ADDR_SECOND_LANE_VIEW) |=> HRDATA == $past(res1_bus)
	) else $error("lane view returned a wrong value");

	chk_full_view_data: assert property (
		s_quiet_read_at(ADDR_FULL_VIEW) |=>
		HRDATA == $past(full) && $stable(s_q.acc_a)
	) else $error("full view wrong or state changed");

	chk_any_excess_bit: assert property (
		s_read_at(ADDR_FIRST_LANE_CTRL) |=>
		HRDATA[F_ANY] == (HRDATA[F_EXA] | HRDATA[F_EXB])
	) else $error("summary excess flag disagrees");

	chk_excess_b_flag: assert property (
		s_read_at(ADDR_FIRST_LANE_CTRL) |=> HRDATA[F_EXB] == $past(ex_b)
	) else $error("accumulator b excess flag wrong");

	chk_excess_a_flag: assert property (
		s_read_at(ADDR_FIRST_LANE_CTRL) |=> HRDATA[F_EXA] == $past(ex_a)
	) else $error("accumulator a excess flag wrong");

	chk_force_top_or: assert property (
		s_read_at(ADDR_VIEW_A) |=> HRDATA[29:28] ==
		($past(res0[29:28]) | $past(s_q.ctrl0[F_FORCE +: 2]))
	) else $error("forced top bits missing on bus read");

	chk_pop_feedback: assert property (
		s_quiet_read_at(ADDR_POP_A) |=> s_q.acc_a ==
		($past(s_q.ctrl0[F_XRES]) ? $past(res1) : $past(res0))
	) else $error("pop loaded a wrong accumulator value");

	chk_raw_bypass: assert property (
		s_q.ctrl0[F_RAW] |-> res0 == s_q.off_a +
		(s_q.ctrl0[F_XIN] ? s_q.acc_b : s_q.acc_a)
	) else $error("raw add bypass result wrong");

	chk_mask_low_zero: assert property (
		!s_q.ctrl0[F_RAW] &&
		(s_q.ctrl0[F_MSB +: 5] >= s_q.ctrl0[F_LSB +: 5]) |->
		((res0 - s_q.off_a) &
		~(32'hffff_ffff << s_q.ctrl0[F_LSB +: 5])) == 32'h0
	) else $error("bits below mask bottom not zero");

	chk_status_sticky: assert property (
		s_q.status[ST_POP] &&
		!(wr_en && wr_addr == ADDR_IRQ_STATUS && HWDATA[ST_POP]) |=>
		s_q.status[ST_POP]
	) else $error("pop status bit dropped without a clear");

	sequence s_write_at(logic [11:0] a);
		wr_en && (wr_addr == a);
	endsequence

	chk_shift_window: assert property (
		!s_q.ctrl0[F_XIN] |-> (m0 & win0) ==
		((s_q.acc_a >> s_q.ctrl0[F_SHIFT +: 5]) & win0)
	) else $error("shifted window of accumulator a wrong");

	chk_swap_operand: assert property (
		s_q.ctrl0[F_XIN] |-> (m0 & win0) ==
		((s_q.acc_b >> s_q.ctrl0[F_SHIFT +: 5]) & win0)
	) else $error("swapped operand not used by first lane");

	chk_sign_fill_top: assert property (
		s_q.ctrl0[F_SIGN] && m0[s_q.ctrl0[F_MSB +: 5]] |->
		&(m0 | (32'hffff_ffff >> (5'h1f - s_q.ctrl0[F_MSB +: 5])))
	) else $error("sign fill above mask top missing");

	chk_first_lane_sum: assert property (
		!s_q.ctrl0[F_RAW] |-> res0 == s_q.off_a + m0
	) else $error("first lane result is not offset plus masked value");

	chk_second_lane_sum: assert property (
		!s_q.ctrl1[F_RAW] |-> res1 == s_q.off_b + m1
	) else $error("second lane result is not offset plus masked value");

	chk_clamp_stored: assert property (
		s_write_at(ADDR_FIRST_LANE_CTRL) |=>
		s_q.ctrl0[F_CLAMP] == $past(HWDATA[F_CLAMP])
	) else $error("clamp bit not stored as written");

	chk_pop_loads_both: assert property (
		pop && !wr_en |=>
		s_q.acc_a ==
		($past(s_q.ctrl0[F_XRES]) ? $past(res1) : $past(res0)) &&
		s_q.acc_b ==
		($past(s_q.ctrl1[F_XRES]) ? $past(res0) : $past(res1))
	) else $error("pop did not load both accumulators");

	chk_excess_event: assert property (
		$rose(ex_any) |=> s_q.status[ST_EXCESS]
	) else $error("excess rise did not set its status bit");

	chk_pop_status: assert property (
		pop |=> s_q.status[ST_POP]
	) else $error("pop did not set its status bit");

	chk_irq_level: assert property (
		IRQ == |(s_q.status & s_q.mask)
	) else $error("interrupt level disagrees with status and mask");

	chk_bus_okay: assert property (
		HREADYOUT && !HRESP
	) else $error("bus slave inserted a wait or an error");

endmodule : ilc_lane_ctrl

// ==== rtl/ilc_pkg.sv ====
// Package: register map, control field layout and reset values.
package ilc_pkg;

	localparam logic [11:0] ADDR_ACCUM_A = 12'h0c0;
	localparam logic [11:0] ADDR_ACCUM_B = 12'h0c4;
	localparam logic [11:0] ADDR_OFFSET_A = 12'h0c8;
	localparam logic [11:0] ADDR_OFFSET_B = 12'h0cc;
	localparam logic [11:0] ADDR_OFFSET_C = 12'h0d0;
	localparam logic [11:0] ADDR_POP_A = 12'h0d4;
	localparam logic [11:0] ADDR_POP_B = 12'h0d8;
	localparam logic [11:0] ADDR_POP_FULL = 12'h0dc;
	localparam logic [11:0] ADDR_VIEW_A = 12'h0e0;
	localparam logic [11:0] ADDR_SECOND_LANE_VIEW = 12'h0e4;
	localparam logic [11:0] ADDR_FULL_VIEW = 12'h0e8;
	localparam logic [11:0] ADDR_FIRST_LANE_CTRL = 12'h0ec;
	localparam logic [11:0] ADDR_SECOND_LANE_CTRL = 12'h0f0;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h1f0;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h1f4;

	localparam int F_SHIFT = 0;
	localparam int F_LSB = 5;
	localparam int F_MSB = 10;
	localparam int F_SIGN = 15;
	localparam int F_XIN = 16;
	localparam int F_XRES = 17;
	localparam int F_RAW = 18;
	localparam int F_FORCE = 19;
	localparam int F_CLAMP = 22;
	localparam int F_EXA = 23;
	localparam int F_EXB = 24;
	localparam int F_ANY = 25;
	localparam int FORCE_POS = 28;

	localparam logic [31:0] CTRL_WR_MASK = 32'h005f_ffff;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	localparam int ST_POP = 0;
	localparam int ST_EXCESS = 1;

	localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : ilc_pkg

// ==== tb/ilc_bus_model.sv ====
// Bus master model standing in for a processor core on the register bus.
module ilc_bus_model
	import ilc_pkg::*;
(
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
	end

	// Each phase is held until hready is seen high at an edge; the bound
	// turns a hung slave into a reported failure instead of a stuck run.
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		n = 0;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		@(posedge clk);
		while (hready !== 1'b1 && n < 64) begin
			@(posedge clk);
			n++;
		end
		ok = (hready === 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= wr ? d : ~hwdata;
		@(posedge clk);
		while (hready !== 1'b1 && n < 128) begin
			@(posedge clk);
			n++;
		end
		q = hrdata;
		ok = ok && (hready === 1'b1);
	endtask : xfer
endmodule : ilc_bus_model

// ==== tb/testbench.sv ====
// Self-checking bench for the interpolator lane block with a reference model.
module testbench
	import ilc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic CLK;
	logic RST_N;
	logic hsel, hwrite, HREADYOUT, HRESP, IRQ;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, HRDATA;
	int fail_count = 0;
	int compares = 0;
	logic [31:0] seed = 32'h7d0e2627;
	logic [31:0] acc_a, acc_b, off_a, off_b, off_c, c0, c1;
	logic [31:0] r0, r1, m0, m1, full, flags;

	ilc_lane_ctrl ilc_lane_ctrl_i(.CLK(CLK), .RST_N(RST_N), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));
	ilc_bus_model ilc_bus_model_i(.clk(CLK), .hready(HREADYOUT),
		.hrdata(HRDATA), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function logic [31:0] rctl();
		logic [31:0] v;
		v = rnd();
		v[14:10] = v[9:5] + 5'(rnd() % (32 - v[9:5]));
		return v;
	endfunction : rctl

	function logic [31:0] shmask(input logic [31:0] v, input logic [31:0] c);
		logic [31:0] s;
		s = v >> c[4:0];
		for (int i = 0; i < 32; i++) begin
			if (i < c[9:5] || i > c[14:10]) begin
				s[i] = (c[15] && i > c[14:10]) ? s[c[14:10]] : 1'b0;
			end
		end
		return s;
	endfunction : shmask

	task model();
		logic [31:0] s0, s1;
		logic ea, eb;
		s0 = c0[16] ? acc_b : acc_a;
		s1 = c1[16] ? acc_a : acc_b;
		m0 = shmask(s0, c0);
		m1 = shmask(s1, c1);
		r0 = off_a + (c0[18] ? s0 : m0);
		r1 = off_b + (c1[18] ? s1 : m1);
		full = off_c + m0 + m1;
		ea = |(((acc_a >> c0[4:0]) >> c0[14:10]) >> 1);
		eb = |(((acc_b >> c0[4:0]) >> c0[14:10]) >> 1);
		flags = {6'h0, ea | eb, eb, ea, 23'h0};
	endtask : model

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task end_of_test();
		$display("Mismatches %0d of %0d compares", fail_count, compares);
		if (fail_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic ok;
		ilc_bus_model_i.xfer(w, a, d, q, ok);
		if (ok !== 1'b1) begin
			fail_count++;
			end_of_test();
		end
	endtask : bus

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
		chk({31'h0, HRESP}, 32'h0);
	endtask : rdc

	function logic [31:0] forced(input logic [31:0] v, input logic [31:0] c);
		return v | {2'h0, c[20:19], 28'h0};
	endfunction : forced

	// The interrupt level follows its cause one edge late, so allow two.
	task irq_is(input logic e);
		repeat (2) @(posedge CLK);
		#1;
		chk({31'h0, IRQ}, {31'h0, e});
	endtask : irq_is

	task pop_check(input logic [11:0] a, input logic [31:0] exp);
		rdc(a, exp);
		acc_a = c0[17] ? r1 : r0;
		acc_b = c1[17] ? r0 : r1;
		rdc(ADDR_ACCUM_A, acc_a);
		rdc(ADDR_ACCUM_B, acc_b);
	endtask : pop_check

	initial begin
		RST_N = 1'b0;
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		rdc(ADDR_FIRST_LANE_CTRL, CTRL_RESET);
		rdc(ADDR_SECOND_LANE_VIEW, WORD_RESET);
		rdc(ADDR_FULL_VIEW, WORD_RESET);
		wr(12'h100, rnd());
		rdc(12'h100, WORD_RESET);
		for (int it = 0; it < 40; it++) begin
			acc_a = rnd();
			acc_b = rnd();
			off_a = rnd();
			off_b = rnd();
			off_c = rnd();
			c0 = rctl();
			c1 = rctl();
			wr(ADDR_ACCUM_A, acc_a);
			wr(ADDR_ACCUM_B, acc_b);
			wr(ADDR_OFFSET_A, off_a);
			wr(ADDR_OFFSET_B, off_b);
			wr(ADDR_OFFSET_C, off_c);
			wr(ADDR_FIRST_LANE_CTRL, c0);
			wr(ADDR_SECOND_LANE_CTRL, c1);
			model();
			rdc(ADDR_SECOND_LANE_VIEW, r1 | {2'h0, c1[20:19], 28'h0});
			rdc(ADDR_FULL_VIEW, full);
			rdc(ADDR_VIEW_A, r0 | {2'h0, c0[20:19], 28'h0});
			rdc(ADDR_FIRST_LANE_CTRL, (c0 & CTRL_WR_MASK) | flags);
			rdc(ADDR_ACCUM_A, acc_a);
			rdc(ADDR_ACCUM_B, acc_b);
			rdc(ADDR_SECOND_LANE_CTRL, c1 & CTRL_WR_MASK);
			model();
			// Rotate over the three pop ports so each one loads the pair.
			if (it % 3 == 0) begin
				pop_check(ADDR_POP_A, forced(r0, c0));
			end else if (it % 3 == 1) begin
				pop_check(ADDR_POP_B, forced(r1, c1));
			end else begin
				pop_check(ADDR_POP_FULL, full);
			end
		end
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_IRQ_STATUS, 32'h3);
		irq_is(1'b0);
		model();
		pop_check(ADDR_POP_A, forced(r0, c0));
		irq_is(1'b1);
		wr(ADDR_IRQ_MASK, 32'h0);
		irq_is(1'b0);
		wr(ADDR_IRQ_MASK, 32'h1);
		irq_is(1'b1);
		wr(ADDR_IRQ_STATUS, 32'h1);
		irq_is(1'b0);
		// The excess status bit is set by a rise, so one clear sticks.
		wr(ADDR_FIRST_LANE_CTRL, 32'h0);
		wr(ADDR_ACCUM_A, 32'h0);
		wr(ADDR_ACCUM_B, 32'h0);
		wr(ADDR_IRQ_STATUS, 32'h3);
		wr(ADDR_IRQ_MASK, 32'h2);
		irq_is(1'b0);
		wr(ADDR_ACCUM_A, 32'h2);
		irq_is(1'b1);
		rdc(ADDR_IRQ_STATUS, 32'h2);
		wr(ADDR_IRQ_STATUS, 32'h2);
		irq_is(1'b0);
		rdc(ADDR_FIRST_LANE_CTRL, 32'h0280_0000);
		// A second reset in mid-run must bring the registers back to zero.
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		rdc(ADDR_FIRST_LANE_CTRL, CTRL_RESET);
		rdc(ADDR_ACCUM_A, WORD_RESET);
		rdc(ADDR_IRQ_MASK, WORD_RESET);
		wr(ADDR_IRQ_MASK, 32'h3);
		irq_is(1'b0);
		end_of_test();
	end
endmodule : testbench
